// *** pkg/instr_decoder_consts.vh ***
// Constants for the instruction word decoder.
//
// Behaviour
// - Every single-word instruction is 24 bits, with an 8-bit opcode on top and operand fields below it.
// - Each opcode falls into one of four categories (word/byte, bit, literal, control) that decide how the operands are split.
// - Working-register word/byte instructions yield a plain first source, a second source with mode and a result with mode.
// - File-register word/byte instructions yield a file address and a result that goes back to the file or to working register zero.
// - Bit instructions yield a working or file register target and a bit position from a literal or from a working register.
// - Literal moves load a literal into a working or file register; literal arithmetic uses the first source, with a result register only when it differs.
// - Exactly three opcodes take two words, and the upper 8 bits of the second word are zero.
// - A second word fetched on its own executes as a no-operation.
// - Other single-word instructions take one cycle, or two when a condition is true or the program counter changes, the extra cycle being a no-operation.
// - Jumps, computed jumps, indirect calls and jumps, table reads and writes and returns take two or three cycles.
// - A performed skip takes two cycles over a single-word instruction and three over a double-word one.
// - Every double-word instruction executes in two cycles.
// - Control instructions yield a program address where one applies, and table accesses yield an access mode.
`ifndef INSTR_DECODER_CONSTS_VH
`define INSTR_DECODER_CONSTS_VH

// ---------------------------------------------
// Word layout
// ---------------------------------------------
`define WORD_W 24
`define OPC_HI 23
`define OPC_LO 16
`define OPC_ZERO 8'h00

// Category is taken from the top three opcode bits.
`define CAT_HI 23
`define CAT_LO 21
`define CAT_CTRL 3'h0
`define CAT_DEFAULT_WORKING_REGISTER_A 3'h1
`define CAT_DEFAULT_WORKING_REGISTER_B 3'h2
`define CAT_FILE 3'h3
`define CAT_BIT_A 3'h4
`define CAT_BIT_B 3'h5

// One-hot category outputs.
`define CATOH_WORD 4'h1
`define CATOH_BIT 4'h2
`define CATOH_LIT 4'h4
`define CATOH_CTRL 4'h8

// ---------------------------------------------
// Opcodes
// ---------------------------------------------
`define OP_NOP 8'h00
`define OP_JUMP 8'h02
`define OP_COMPUTED_JUMP 8'h03
`define OP_INDIRECT_CALL 8'h04
`define OP_INDIRECT_JUMP 8'h05
`define OP_TABLE_READ 8'h06
`define OP_TABLE_WRITE 8'h07
`define OP_RETURN 8'h08
`define OP_INTERRUPT_RETURN 8'h09
`define OP_COND_BRANCH 8'h0A
`define OP_LONG_CALL 8'h0B
`define OP_LONG_JUMP 8'h0C
`define OP_DOUBLE_MOVE 8'h3F
`define OP_BIT_SKIP 8'h9F
`define OP_LIT_TO_DEFAULT_WORKING_REGISTER 8'hC0
`define OP_LIT_TO_FILE 8'hC1

// ---------------------------------------------
// Operand field positions
// ---------------------------------------------
`define F_FIRST_HI 15
`define F_FIRST_LO 12
`define F_RMODE_HI 11
`define F_RMODE_LO 10
`define F_RREG_HI 9
`define F_RREG_LO 6
`define F_SMODE_HI 5
`define F_SMODE_LO 4
`define F_SREG_HI 3
`define F_SREG_LO 0
`define F_FILE_DEST 15
`define F_FILE_HI 12
`define F_FILE_LO 0
`define F_BIT_BY_REG 11
`define F_BIT_TO_FILE 10
`define F_BIT_FILE_HI 9
`define F_TMODE_HI 13
`define F_TMODE_LO 12
`define F_LIT_SEP_DEST 11
`define F_LIT5_HI 10
`define F_LIT5_LO 6
`define F_ADDR_HI_W 7
`define DEFAULT_WORKING_REGISTER_ZERO 4'h0

// ---------------------------------------------
// Cycle counts
// ---------------------------------------------
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2
`define CYC_THREE 2'h3

`endif

// *** hw/instr_fields.v ***
// Operand field splitter for one instruction word.
`timescale 1ns/10ps
`include "instr_decoder_consts.vh"

module instr_fields (
  input wire [23:0] i_word,
  output reg [3:0] o_category,
  output reg [3:0] o_first_source_reg,
  output reg [3:0] o_second_source_reg,
  output reg [1:0] o_second_mode,
  output reg [3:0] o_result_reg,
  output reg [1:0] o_result_mode,
  output reg [12:0] o_file_addr,
  output reg o_to_file,
  output reg [3:0] o_bit_pos,
  output reg o_bit_by_reg,
  output reg [15:0] o_literal,
  output reg [1:0] o_table_mode
);
  wire [7:0] opc = i_word[`OPC_HI:`OPC_LO];
  wire [2:0] cat = i_word[`CAT_HI:`CAT_LO];

  always @* begin
    o_category = `CATOH_LIT;
    o_first_source_reg = i_word[`F_FIRST_HI:`F_FIRST_LO];
    o_second_source_reg = i_word[`F_SREG_HI:`F_SREG_LO];
    o_second_mode = i_word[`F_SMODE_HI:`F_SMODE_LO];
    o_result_reg = i_word[`F_RREG_HI:`F_RREG_LO];
    o_result_mode = i_word[`F_RMODE_HI:`F_RMODE_LO];
    o_file_addr = 13'h0000;
    o_to_file = 1'b0;
    o_bit_pos = 4'h0;
    o_bit_by_reg = 1'b0;
    o_literal = i_word[15:0];
    o_table_mode = 2'h0;
    if (cat == `CAT_CTRL) begin
      o_category = `CATOH_CTRL;
      o_table_mode = i_word[`F_TMODE_HI:`F_TMODE_LO];
    end else if (cat == `CAT_DEFAULT_WORKING_REGISTER_A || cat == `CAT_DEFAULT_WORKING_REGISTER_B) begin
      o_category = `CATOH_WORD;
    end else if (cat == `CAT_FILE) begin
      o_category = `CATOH_WORD;
      o_to_file = i_word[`F_FILE_DEST];
      o_file_addr = i_word[`F_FILE_HI:`F_FILE_LO];
      o_result_reg = `DEFAULT_WORKING_REGISTER_ZERO;
      o_result_mode = 2'h0;
    end else if (cat == `CAT_BIT_A || cat == `CAT_BIT_B) begin
      o_category = `CATOH_BIT;
      o_bit_by_reg = i_word[`F_BIT_BY_REG];
      o_bit_pos = i_word[`F_FIRST_HI:`F_FIRST_LO];
      o_to_file = i_word[`F_BIT_TO_FILE];
      o_file_addr = {3'h0, i_word[`F_BIT_FILE_HI:0]};
    end else if (opc == `OP_LIT_TO_DEFAULT_WORKING_REGISTER) begin
      o_literal = {4'h0, i_word[15:4]};
      o_result_reg = i_word[`F_SREG_HI:`F_SREG_LO];
      o_result_mode = 2'h0;
    end else if (opc == `OP_LIT_TO_FILE) begin
      o_literal = {8'h00, i_word[15:8]};
      o_file_addr = {5'h00, i_word[7:0]};
      o_to_file = 1'b1;
    end else begin
      o_literal = {11'h000, i_word[`F_LIT5_HI:`F_LIT5_LO]};
      if (i_word[`F_LIT_SEP_DEST]) begin
        o_result_reg = i_word[`F_SREG_HI:`F_SREG_LO];
        o_result_mode = i_word[`F_SMODE_HI:`F_SMODE_LO];
      end else begin
        o_result_reg = i_word[`F_FIRST_HI:`F_FIRST_LO];
        o_result_mode = 2'h0;
      end
    end
  end
endmodule

// *** hw/instr_decoder.v ***
// Instruction decoder with double-word assembly and cycle accounting.
`timescale 1ns/10ps
`include "instr_decoder_consts.vh"

module instr_decoder (
  input wire i_clk,
  input wire i_rst,
  input wire i_word_valid,
  input wire [23:0] i_word,
  input wire i_cond_true,
  output wire o_word_ready,
  output reg o_issue,
  output reg o_nop,
  output reg o_second,
  output reg o_second_ok,
  output reg o_double,
  output reg o_pc_change,
  output reg [1:0] o_cycles,
  output reg [7:0] o_opcode,
  output reg [3:0] o_category,
  output reg [3:0] o_first_source_reg,
  output reg [3:0] o_second_source_reg,
  output reg [1:0] o_second_mode,
  output reg [3:0] o_result_reg,
  output reg [1:0] o_result_mode,
  output reg [12:0] o_file_addr,
  output reg o_to_file,
  output reg [3:0] o_bit_pos,
  output reg o_bit_by_reg,
  output reg [15:0] o_literal,
  output reg [1:0] o_table_mode,
  output reg [22:0] o_prog_addr
);

  // ---------------------------------------------
  // States
  // ---------------------------------------------
  localparam [4:0] ST_RUN = 5'h01;
  localparam [4:0] ST_WORD2 = 5'h02;
  localparam [4:0] ST_STALL = 5'h04;
  localparam [4:0] ST_SKIP1 = 5'h08;
  localparam [4:0] ST_SKIP2 = 5'h10;

  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [1:0] stall_reg;
  reg [1:0] stall_next;

  wire [7:0] opc = i_word[`OPC_HI:`OPC_LO];
  wire take = i_word_valid && o_word_ready;

  wire [3:0] f_category;
  wire [3:0] f_first;
  wire [3:0] f_second;
  wire [1:0] f_smode;
  wire [3:0] f_result;
  wire [1:0] f_rmode;
  wire [12:0] f_file;
  wire f_to_file;
  wire [3:0] f_bit;
  wire f_bit_by_reg;
  wire [15:0] f_literal;
  wire [1:0] f_tmode;

  instr_fields u_fields (
    .i_word(i_word),
    .o_category(f_category),
    .o_first_source_reg(f_first),
    .o_second_source_reg(f_second),
    .o_second_mode(f_smode),
    .o_result_reg(f_result),
    .o_result_mode(f_rmode),
    .o_file_addr(f_file),
    .o_to_file(f_to_file),
    .o_bit_pos(f_bit),
    .o_bit_by_reg(f_bit_by_reg),
    .o_literal(f_literal),
    .o_table_mode(f_tmode)
  );

  // ---------------------------------------------
  // Word classification
  // ---------------------------------------------
  wire is_double = (opc == `OP_LONG_CALL) || (opc == `OP_LONG_JUMP) ||
                   (opc == `OP_DOUBLE_MOVE);
  wire is_skip = (opc == `OP_BIT_SKIP);

  // ---------------------------------------------
  // Cycle table
  // ---------------------------------------------
  // Total cycles of a single-word instruction, given its condition.
  // Double-word and skipped-word timing is handled by the sequencer instead.
  reg [1:0] cyc_single;
  reg pc_changes;

  always @* begin
    cyc_single = `CYC_ONE;
    pc_changes = 1'b0;
    case (opc)
      `OP_JUMP: begin
        cyc_single = `CYC_TWO;
        pc_changes = 1'b1;
      end
      `OP_COMPUTED_JUMP: begin
        cyc_single = `CYC_TWO;
        pc_changes = 1'b1;
      end
      `OP_INDIRECT_CALL: begin
        cyc_single = `CYC_TWO;
        pc_changes = 1'b1;
      end
      `OP_INDIRECT_JUMP: begin
        cyc_single = `CYC_TWO;
        pc_changes = 1'b1;
      end
      `OP_TABLE_READ: begin
        cyc_single = `CYC_TWO;
      end
      `OP_TABLE_WRITE: begin
        cyc_single = `CYC_TWO;
      end
      `OP_RETURN: begin
        cyc_single = `CYC_THREE;
        pc_changes = 1'b1;
      end
      `OP_INTERRUPT_RETURN: begin
        cyc_single = `CYC_THREE;
        pc_changes = 1'b1;
      end
      `OP_COND_BRANCH: begin
        if (i_cond_true) begin
          cyc_single = `CYC_TWO;
          pc_changes = 1'b1;
        end
      end
      `OP_BIT_SKIP: begin
        if (i_cond_true) begin
          cyc_single = `CYC_TWO;
        end
      end
      default: begin
        cyc_single = `CYC_ONE;
      end
    endcase
  end

  // A stall cycle holds the fetch; the skip states still take words.
  assign o_word_ready = (state_reg != ST_STALL);

  // ---------------------------------------------
  // Sequencer
  // ---------------------------------------------
  always @* begin
    state_next = state_reg;
    stall_next = stall_reg;
    case (state_reg)
      ST_RUN: begin
        if (take) begin
          if (is_double) begin
            state_next = ST_WORD2;
          end else if (is_skip && i_cond_true) begin
            state_next = ST_SKIP1;
          end else if (cyc_single != `CYC_ONE) begin
            state_next = ST_STALL;
            stall_next = cyc_single - `CYC_ONE;
          end
        end
      end
      ST_WORD2: begin
        if (take) begin
          state_next = ST_RUN;
        end
      end
      ST_STALL: begin
        stall_next = stall_reg - `CYC_ONE;
        if (stall_reg == `CYC_ONE) begin
          state_next = ST_RUN;
        end
      end
      ST_SKIP1: begin
        if (take) begin
          if (is_double) begin
            state_next = ST_SKIP2;
          end else begin
            state_next = ST_RUN;
          end
        end
      end
      ST_SKIP2: begin
        if (take) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
        stall_next = 2'h0;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= ST_RUN;
      stall_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      stall_reg <= stall_next;
    end
  end

  // ---------------------------------------------
  // Event outputs
  // ---------------------------------------------
  wire run_take = take && (state_reg == ST_RUN);
  wire skip_take = take && (state_reg == ST_SKIP1 || state_reg == ST_SKIP2);

  reg issue_next;
  reg nop_next;
  reg second_next;
  reg second_ok_next;

  // A lone zero-topped word decodes as the no-operation opcode.
  always @* begin
    issue_next = run_take;
    nop_next = (state_reg == ST_STALL) || skip_take ||
               (run_take && opc == `OP_NOP);
    second_next = take && (state_reg == ST_WORD2);
    second_ok_next = o_second_ok;
    if (second_next) begin
      second_ok_next = (opc == `OPC_ZERO);
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      o_issue <= 1'b0;
      o_nop <= 1'b0;
      o_second <= 1'b0;
      o_second_ok <= 1'b0;
    end else begin
      o_issue <= issue_next;
      o_nop <= nop_next;
      o_second <= second_next;
      o_second_ok <= second_ok_next;
    end
  end

  // ---------------------------------------------
  // Decoded instruction fields
  // ---------------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_double <= 1'b0;
      o_pc_change <= 1'b0;
      o_cycles <= `CYC_ONE;
      o_opcode <= `OP_NOP;
      o_prog_addr <= 23'h000000;
    end else if (run_take) begin
      o_double <= is_double;
      o_pc_change <= pc_changes ||
                     (is_double && opc != `OP_DOUBLE_MOVE);
      o_cycles <= is_double ? `CYC_TWO : cyc_single;
      o_opcode <= opc;
      o_prog_addr <= {7'h00, i_word[15:0]};
    end else if (take && state_reg == ST_WORD2) begin
      // The second word carries the upper address bits.
      o_prog_addr <= {i_word[`F_ADDR_HI_W-1:0], o_prog_addr[15:0]};
    end else if (take && state_reg == ST_SKIP1 && is_double) begin
      // The skipped instruction's own second word costs one more cycle.
      o_cycles <= `CYC_THREE;
    end
  end

  // ---------------------------------------------
  // Operand fields
  // ---------------------------------------------
  // They load only with a new first word, so they stand through stalls, skips and second words.
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_category <= `CATOH_CTRL;
      o_first_source_reg <= 4'h0;
      o_second_source_reg <= 4'h0;
      o_second_mode <= 2'h0;
      o_result_reg <= 4'h0;
      o_result_mode <= 2'h0;
      o_file_addr <= 13'h0000;
      o_to_file <= 1'b0;
      o_bit_pos <= 4'h0;
      o_bit_by_reg <= 1'b0;
      o_literal <= 16'h0000;
      o_table_mode <= 2'h0;
    end else if (run_take) begin
      o_category <= f_category;
      o_first_source_reg <= f_first;
      o_second_source_reg <= f_second;
      o_second_mode <= f_smode;
      o_result_reg <= f_result;
      o_result_mode <= f_rmode;
      o_file_addr <= f_file;
      o_to_file <= f_to_file;
      o_bit_pos <= f_bit;
      o_bit_by_reg <= f_bit_by_reg;
      o_literal <= f_literal;
      o_table_mode <= f_tmode;
    end
  end

endmodule

// *** tb/instr_decoder_chk.sv ***
// Concurrent port checks for the instruction decoder.
`timescale 1ns/10ps
module instr_decoder_chk (
  input wire i_clk,
  input wire i_rst,
  input wire i_cond_true,
  input wire [23:0] i_word,
  input wire o_word_ready,
  input wire o_issue,
  input wire o_nop,
  input wire o_second,
  input wire o_second_ok,
  input wire o_double,
  input wire o_pc_change,
  input wire [1:0] o_cycles,
  input wire [7:0] o_opcode,
  input wire [3:0] o_category
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence stall_one;
    !o_word_ready ##1 o_nop && o_word_ready;
  endsequence
  sequence stall_two;
    !o_word_ready ##1 !o_word_ready && o_nop ##1 o_nop && o_word_ready;
  endsequence
  AST_OPCODE: assert property (o_issue |-> o_opcode == $past(i_word[23:16]))
    else $error("issued opcode differs from taken word");
  AST_CATEGORY: assert property (o_issue |-> o_category == ((o_opcode[7:5] == 3'h0) ? 4'h8 :
    !o_opcode[7] ? 4'h1 : o_opcode[6] ? 4'h4 : 4'h2)) else $error("wrong category");
  AST_JUMP: assert property (o_issue && o_opcode == 8'h02 |->
    (o_cycles == 2'h2 && o_pc_change) ##0 stall_one) else $error("jump timing wrong");
  AST_RETURN: assert property (o_issue && o_opcode[7:1] == 7'h04 |->
    (o_cycles == 2'h3 && o_pc_change) ##0 stall_two) else $error("return timing wrong");
  AST_DOUBLE: assert property (o_issue |-> o_double == (o_opcode == 8'h0B || o_opcode == 8'h0C ||
    o_opcode == 8'h3F)) else $error("double-word flag wrong");
  AST_DOUBLE_CYC: assert property (o_issue && o_double |-> o_cycles == 2'h2)
    else $error("double-word cycle count wrong");
  AST_SECOND_OK: assert property (o_second |-> o_second_ok == ($past(i_word[23:16]) == 8'h00))
    else $error("second word flag wrong");
  AST_LONE_NOP: assert property (o_issue && o_opcode == 8'h00 |-> o_nop)
    else $error("lone second word not a no-operation");
  AST_COND: assert property (o_issue && o_opcode == 8'h0A |-> o_pc_change == $past(i_cond_true) &&
    o_cycles == ($past(i_cond_true) ? 2'h2 : 2'h1)) else $error("conditional branch timing wrong");
  AST_SINGLE: assert property (o_issue && o_opcode[7:6] == 2'h3 |-> o_cycles == 2'h1 && o_word_ready)
    else $error("literal instruction not single cycle");
endmodule
bind instr_decoder instr_decoder_chk instr_decoder_chk_i (.i_clk, .i_rst, .i_cond_true, .i_word, .o_word_ready,
  .o_issue, .o_nop, .o_second, .o_second_ok, .o_double, .o_pc_change, .o_cycles, .o_opcode, .o_category);

// *** tb/testbench.sv ***
// Self-checking bench for the instruction decoder.
`timescale 1ns/10ps
module testbench;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_word_valid = 1'b0;
  logic [23:0] i_word = 24'h000000;
  logic i_cond_true = 1'b0;
  wire o_word_ready, o_issue, o_nop, o_second, o_second_ok, o_double, o_pc_change, o_to_file, o_bit_by_reg;
  wire [1:0] o_cycles, o_second_mode, o_result_mode, o_table_mode;
  wire [7:0] o_opcode;
  wire [3:0] o_category, o_first_source_reg, o_second_source_reg, o_result_reg, o_bit_pos;
  wire [12:0] o_file_addr;
  wire [15:0] o_literal;
  wire [22:0] o_prog_addr;
  int fail_count = 0;
  int tests_run = 0;
  instr_decoder instr_decoder_i (.i_clk, .i_rst, .i_word_valid, .i_word, .i_cond_true, .o_word_ready, .o_issue,
    .o_nop, .o_second, .o_second_ok, .o_double, .o_pc_change, .o_cycles, .o_opcode, .o_category,
    .o_first_source_reg, .o_second_source_reg, .o_second_mode, .o_result_reg, .o_result_mode, .o_file_addr,
    .o_to_file, .o_bit_pos, .o_bit_by_reg, .o_literal, .o_table_mode, .o_prog_addr);
  initial begin
    forever #4 i_clk = ~i_clk;
  end
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Offers a word and holds it until the edge that takes it; last drops valid after that edge.
  task automatic put(input logic [23:0] w, input logic c, input logic last);
    int n;
    n = 0;
    i_word <= w;
    i_cond_true <= c;
    i_word_valid <= 1'b1;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_word_ready !== 1'b1 && n < 8);
    if (o_word_ready !== 1'b1) begin
      fail_count++;
      complete_run();
    end
    @(posedge i_clk);
    if (last) i_word_valid <= 1'b0;
  endtask
  task automatic one(input logic [23:0] w, input logic c);
    @(posedge i_clk);
    put(w, c, 1'b1);
    @(negedge i_clk);
  endtask
  task automatic multi(input logic [7:0] op, input logic c, input logic [1:0] cyc, input logic pc);
    one({op, 16'hA5B6}, c);
    chk(o_issue, 1'b1);
    chk(o_cycles, cyc);
    chk(o_pc_change, pc);
    if (op == 8'h02) chk(o_prog_addr[15:0], 16'hA5B6);
    if (op[7:1] == 7'h03) chk(o_table_mode, 2'h2);
    for (int k = 1; k < cyc; k++) begin
      chk(o_word_ready, 1'b0);
      @(negedge i_clk);
      chk(o_nop, 1'b1);
    end
    chk(o_word_ready, 1'b1);
  endtask
  task automatic fields();
    one(24'h20995C, 1'b0);
    chk({o_category, o_first_source_reg, o_second_mode, o_second_source_reg}, 14'h065C);
    chk({o_result_mode, o_result_reg}, 6'h25);
    one(24'h600ABC, 1'b0);
    chk({o_to_file, o_result_reg, o_file_addr}, 18'h00ABC);
    one(24'h608123, 1'b0);
    chk({o_to_file, o_file_addr}, 14'h2123);
    one(24'h807FFF, 1'b0);
    chk({o_category, o_bit_pos, o_bit_by_reg, o_to_file}, 10'h09F);
    one(24'hC03A56, 1'b0);
    chk({o_category, o_literal}, 20'h403A5);
    one(24'hE0B540, 1'b0);
    chk({o_first_source_reg, o_result_reg, o_literal}, 24'hBB0015);
    one(24'hE02B5A, 1'b0);
    chk({o_result_mode, o_result_reg, o_literal}, 22'h1A000D);
    one(24'hC1A57E, 1'b0);
    chk({o_category, o_to_file, o_file_addr}, 18'h1207E);
    chk(o_literal, 16'h00A5);
  endtask
  task automatic doubles();
    @(posedge i_clk);
    put(24'h0B1234, 1'b0, 1'b0);
    put(24'h00005A, 1'b0, 1'b1);
    @(negedge i_clk);
    chk({o_second, o_second_ok, o_double, o_cycles}, 5'h1E);
    chk(o_prog_addr, 23'h5A1234);
    @(posedge i_clk);
    put(24'h0C0000, 1'b0, 1'b0);
    put(24'h120003, 1'b0, 1'b1);
    @(negedge i_clk);
    chk({o_second, o_second_ok}, 2'h2);
    one(24'h00FFFF, 1'b0);
    chk({o_nop, o_second}, 2'h2);
  endtask
  task automatic skips();
    @(posedge i_clk);
    put(24'h9F0000, 1'b1, 1'b0);
    put(24'hC00011, 1'b0, 1'b1);
    @(negedge i_clk);
    chk({o_nop, o_cycles, o_opcode}, 11'h69F);
    @(posedge i_clk);
    put(24'h9F0000, 1'b1, 1'b0);
    put(24'h3F0000, 1'b0, 1'b0);
    put(24'h000000, 1'b0, 1'b1);
    @(negedge i_clk);
    chk({o_nop, o_second, o_cycles, o_opcode}, 12'hB9F);
    one(24'h9F0000, 1'b0);
    chk({o_cycles, o_pc_change, o_word_ready}, 4'h5);
    one(24'hC00011, 1'b0);
    chk({o_issue, o_nop}, 2'h2);
  endtask
  initial begin
    repeat (15) @(posedge i_clk);
    @(negedge i_clk);
    chk({o_word_ready, o_issue, o_nop, o_cycles, o_category}, 9'h118);
    @(posedge i_clk);
    i_rst <= 1'b0;
    for (int i = 2; i < 10; i++) begin
      multi(i[7:0], 1'b0, (i > 7) ? 2'h3 : 2'h2, !(i == 6 || i == 7));
    end
    multi(8'h0A, 1'b0, 2'h1, 1'b0);
    multi(8'h0A, 1'b1, 2'h2, 1'b1);
    fields();
    doubles();
    skips();
    complete_run();
  end
endmodule
